/* File: acr_params.svh */
// Constants of the conversion result readout chain
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
`define ACR_RES_W 12
`define ACR_ODR_W 24
`define ACR_RES_ONES 12'hFFF
`define ACR_ODR_ONES 24'hFFFFFF
`define ACR_PAD_ZERO 4'h0
`define ACR_TAIL_ZERO 7'h00
`define ACR_TOP_ZERO 8'h00
`define ACR_TAP_PLAIN 5'h0F
`define ACR_TAP_MARK 5'h17
`define ACR_CNT_MAX 5'h1F
`define ACR_PAD_LO 5'h0C
`define ACR_PAD_HI 5'h0F
`define ACR_MARK_CNT 5'h10
`define ACR_EOS_LAST 2'h2
`define ACR_OSC_LAST 4'h1
`define ACR_CLK_NS 50
`define ACR_QUIET_NS 20
`define ACR_QUIET_CYC ((`ACR_QUIET_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`endif

/* File: acr_pkg.sv */
// Types of the conversion result readout chain
`default_nettype none
package acr_pkg;
	typedef enum logic [0:0] {
		EOS_IDLE,
		EOS_COUNT
	} acr_eos_state_t;
	typedef logic [23:0] acr_odr_t;
endpackage : acr_pkg
`default_nettype wire

/* File: acr_readout.sv */
// Result readout path: output data register, serial shifter and chain pass-through
`include "acr_params.svh"
`default_nettype none
module acr_readout (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic sclk,
	input wire logic frameSyncN,
	input wire logic conversionStartPin,
	input wire logic convDone,
	input wire logic [`ACR_RES_W-1:0] convData,
	input wire logic convChannel,
	input wire logic chainModeSelect,
	input wire logic markerEnable,
	input wire logic autoTrigger,
	input wire logic cclkFromSclk,
	input wire logic softwareResetBitN,
	input wire logic chainDataIn,
	output logic eocOut,
	output logic eocOe,
	output logic sdoOut,
	output logic sdoOe,
	output logic endOfSampling,
	output logic conversionClockTick,
	output acr_pkg::acr_odr_t odrWord
);
	import acr_pkg::*;

	// Reset and software reset merged
	logic rstAll;
	assign rstAll = srst | ~softwareResetBitN;

	function automatic acr_odr_t buildWord(input logic [`ACR_RES_W-1:0] res,
			input logic chan, input logic mark);
		buildWord = mark ? {res, `ACR_PAD_ZERO, chan, `ACR_TAIL_ZERO}
			: {`ACR_TOP_ZERO, res, `ACR_PAD_ZERO};
	endfunction : buildWord

	// ---------------- core_clk domain ----------------
	logic sclkHalf_r;
	logic [2:0] syncQ;
	logic csIdle;
	logic startS;
	logic halfS;
	acr_sync #(.WIDTH(3)) u_sync (
		.clk(core_clk),
		.asyncIn({sclkHalf_r, conversionStartPin, frameSyncN}),
		.syncOut(syncQ)
	);
	assign csIdle = syncQ[0];
	assign startS = syncQ[1];
	assign halfS = syncQ[2];

	logic startPrev_r;
	logic halfPrev_r;
	logic csPrev_r;
	always_ff @(posedge core_clk) begin
		if (rstAll) begin
			startPrev_r <= startS; // Follows the pin: no false edge after reset
			halfPrev_r <= 1'b0;
			csPrev_r <= 1'b1;
		end else begin
			startPrev_r <= startS;
			halfPrev_r <= halfS;
			csPrev_r <= csIdle;
		end
	end

	logic startFall;
	logic halfRise;
	assign startFall = startPrev_r & ~startS;
	// Rising edges only, one tick per SCLK/2 period; needs SCLK slower than core_clk
	assign halfRise = halfS & ~halfPrev_r;

	// Internal oscillator stand-in: divided core clock
	logic [3:0] oscCnt_r;
	logic oscTick;
	assign oscTick = (oscCnt_r == `ACR_OSC_LAST);
	always_ff @(posedge core_clk) begin
		if (rstAll || oscTick)
			oscCnt_r <= 4'h0;
		else
			oscCnt_r <= oscCnt_r + 4'h1;
	end

	logic cclkTick;
	assign cclkTick = cclkFromSclk ? halfRise : oscTick;
	assign conversionClockTick = cclkTick;

	// End of sampling sequencing
	acr_eos_state_t eosState_r;
	logic [1:0] eosCnt_r;
	logic autoEos;
	assign autoEos = (eosState_r == EOS_COUNT) && cclkTick && (eosCnt_r == `ACR_EOS_LAST);
	always_ff @(posedge core_clk) begin
		if (rstAll) begin
			eosState_r <= EOS_IDLE;
			eosCnt_r <= 2'h0;
		end else begin
			case (eosState_r)
				EOS_IDLE: begin
					eosCnt_r <= 2'h0;
					if (convDone && autoTrigger)
						eosState_r <= EOS_COUNT;
				end
				EOS_COUNT: begin
					if (!autoTrigger) begin
						eosState_r <= EOS_IDLE;
					end else if (cclkTick) begin
						eosCnt_r <= eosCnt_r + 2'h1;
						if (eosCnt_r == `ACR_EOS_LAST)
							eosState_r <= EOS_IDLE;
					end
				end
				default: eosState_r <= EOS_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rstAll)
			endOfSampling <= 1'b0;
		else
			endOfSampling <= autoTrigger ? autoEos : startFall;
	end

	// Result holding register; no new conversion keeps old data
	logic [`ACR_RES_W-1:0] holdRes_r;
	logic holdChan_r;
	always_ff @(posedge core_clk) begin
		if (rstAll) begin
			holdRes_r <= `ACR_RES_ONES;
			holdChan_r <= 1'b1;
		end else if (convDone) begin
			holdRes_r <= convData;
			holdChan_r <= convChannel;
		end
	end

	// All-ones frame flag, dropped when the first frame closes
	logic onesFlag_r;
	always_ff @(posedge core_clk) begin
		if (rstAll)
			onesFlag_r <= 1'b1;
		else if (csIdle && !csPrev_r)
			onesFlag_r <= 1'b0;
	end

	// Published word: frozen while a frame is open, so the link reads it unsynchronised
	acr_odr_t pendWord_r;
	logic pendOnes_r;
	logic pendMark_r;
	logic pendChain_r;
	always_ff @(posedge core_clk) begin
		if (rstAll) begin
			pendWord_r <= `ACR_ODR_ONES;
			pendOnes_r <= 1'b1;
			pendMark_r <= 1'b1;
			pendChain_r <= 1'b1;
		end else if (csIdle && csPrev_r) begin
			pendWord_r <= onesFlag_r ? `ACR_ODR_ONES
				: buildWord(holdRes_r, holdChan_r, markerEnable);
			pendOnes_r <= onesFlag_r;
			pendMark_r <= markerEnable;
			pendChain_r <= chainModeSelect;
		end
	end
	assign odrWord = pendWord_r;

	// Status pin: end-of-conversion pulse unless it serves as chain input
	logic linkRst_r;
	always_ff @(posedge core_clk) begin
		if (rstAll) begin
			eocOut <= 1'b0;
			linkRst_r <= 1'b1;
		end else begin
			eocOut <= convDone;
			linkRst_r <= 1'b0;
		end
	end
	assign eocOe = ~chainModeSelect;

	// ---------------- sclk domain ----------------
	// SCLK/2 for the conversion clock; reset from the core side
	always_ff @(posedge sclk or posedge linkRst_r) begin
		if (linkRst_r)
			sclkHalf_r <= 1'b0;
		else
			sclkHalf_r <= ~sclkHalf_r;
	end

	// Chain input taken mid-bit, on the rising edge
	logic cdiS_r;
	always_ff @(posedge sclk or posedge frameSyncN) begin
		if (frameSyncN)
			cdiS_r <= 1'b0;
		else
			cdiS_r <= chainDataIn;
	end

	logic insBit;
	assign insBit = pendOnes_r | (pendChain_r & cdiS_r);

	// Output shifter; the frame's own edge closes it
	acr_odr_t odr_r;
	logic started_r;
	logic [4:0] bitCnt_r;
	always_ff @(negedge sclk or posedge frameSyncN) begin
		if (frameSyncN) begin
			odr_r <= 24'h000000;
			started_r <= 1'b0;
		end else begin
			started_r <= 1'b1;
			if (!started_r)
				odr_r <= {pendWord_r[22:0], insBit};
			else
				odr_r <= {odr_r[22:0], insBit};
		end
	end

	always_ff @(negedge sclk or posedge frameSyncN) begin
		if (frameSyncN)
			bitCnt_r <= 5'h00;
		else if (bitCnt_r != `ACR_CNT_MAX)
			bitCnt_r <= bitCnt_r + 5'h01;
	end

	// Tap at word length keeps the chain delay at 16 or 24 bits
	logic tapOdr;
	logic tapPend;
	assign tapOdr = pendMark_r ? odr_r[`ACR_TAP_MARK] : odr_r[`ACR_TAP_PLAIN];
	assign tapPend = pendMark_r ? pendWord_r[`ACR_TAP_MARK] : pendWord_r[`ACR_TAP_PLAIN];
	assign sdoOut = started_r ? tapOdr : tapPend;
	assign sdoOe = ~frameSyncN;

	// ---------------- checks ----------------
	logic [4:0] tapIdx;
	assign tapIdx = (pendMark_r ? `ACR_TAP_MARK : `ACR_TAP_PLAIN) - bitCnt_r;

	hold_load_a: assert property (@(posedge core_clk) disable iff (rstAll)
		convDone |=> (holdRes_r == $past(convData)) && (holdChan_r == $past(convChannel)))
		else $error("held result not loaded at end of conversion");

	manual_eos_a: assert property (@(posedge core_clk) disable iff (rstAll)
		(!autoTrigger && startPrev_r && !startS) |=> endOfSampling)
		else $error("manual end of sampling missed");

	auto_eos_a: assert property (@(posedge core_clk) disable iff (rstAll)
		(autoTrigger && endOfSampling) |-> $past(eosState_r == EOS_COUNT && cclkTick
			&& eosCnt_r == `ACR_EOS_LAST))
		else $error("auto end of sampling not on third conversion clock");

	frame_freeze_a: assert property (@(posedge core_clk) disable iff (rstAll)
		!csIdle |=> $stable(pendWord_r) && $stable(pendOnes_r))
		else $error("published word changed inside a frame");

	reset_ones_a: assert property (@(posedge core_clk)
		rstAll |=> (pendWord_r == `ACR_ODR_ONES) && pendOnes_r && onesFlag_r)
		else $error("reset did not force all ones");

	status_pin_a: assert property (@(posedge core_clk) disable iff (rstAll)
		chainModeSelect |-> !eocOe)
		else $error("status pin driven in chain mode");

	msb_first_a: assert property (@(negedge sclk) disable iff (frameSyncN)
		(bitCnt_r < `ACR_PAD_LO) |-> (sdoOut == pendWord_r[tapIdx]))
		else $error("result bit out of order");

	zero_pad_a: assert property (@(negedge sclk) disable iff (frameSyncN)
		(!pendOnes_r && bitCnt_r >= `ACR_PAD_LO && bitCnt_r <= `ACR_PAD_HI) |-> !sdoOut)
		else $error("pad bits not zero");

	marker_pos_a: assert property (@(negedge sclk) disable iff (frameSyncN)
		(!pendOnes_r && pendMark_r && bitCnt_r == `ACR_MARK_CNT)
			|-> (sdoOut == pendWord_r[`ACR_TAP_MARK - `ACR_MARK_CNT]))
		else $error("marker not in seventeenth place");

	cov_ones_frame: cover property (@(negedge sclk) disable iff (frameSyncN)
		pendOnes_r && bitCnt_r == `ACR_PAD_HI);
	cov_chain_pass: cover property (@(negedge sclk) disable iff (frameSyncN)
		pendChain_r && bitCnt_r == `ACR_TAP_MARK);
	cov_auto_eos: cover property (@(posedge core_clk) disable iff (rstAll)
		autoTrigger && endOfSampling);
endmodule : acr_readout
`default_nettype wire

/* File: acr_sync.sv */
// Two-flop level synchroniser, one per bit
`default_nettype none
module acr_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_r;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// First stage is read only by the second stage
			always_ff @(posedge clk) begin
				meta_r[i] <= asyncIn[i];
				syncOut[i] <= meta_r[i];
			end
		end
	endgenerate
endmodule : acr_sync
`default_nettype wire

/* File: acr_upstream_model.sv */
// Upstream converter feeding the chain data input
`default_nettype none
module acr_upstream_model (
	input wire logic sclk,
	input wire logic frameSyncN,
	input wire logic [15:0] upWord,
	output logic chainDataIn
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] idx_r;
	// Shifts on falling sclk, the far end samples on rising
	always @(negedge sclk or posedge frameSyncN) begin
		if (frameSyncN)
			idx_r <= 5'h00;
		else if (idx_r < 5'h10)
			idx_r <= idx_r + 5'h01;
	end
	// Own word first from frame start, MSB first
	// Past the word or outside frames: inverse of last bit, never a held value
	assign chainDataIn = (!frameSyncN && idx_r < 5'h10) ? upWord[4'hF - idx_r[3:0]] : ~upWord[0];
endmodule : acr_upstream_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench of the result readout path
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 0, srst = 1, sclk = 0, frameSyncN = 1, conversionStartPin = 0;
	logic convDone = 0, convChannel = 0, chainModeSelect = 0, markerEnable = 0;
	logic softwareResetBitN = 1, chainDataIn, eocOut, eocOe, sdoOut, sdoOe;
	logic autoTrigger = 0, cclkFromSclk = 0;
	logic endOfSampling, conversionClockTick;
	logic [11:0] convData = 12'h000;
	logic [15:0] upWord = 16'h0000;
	acr_pkg::acr_odr_t odrWord;
	logic expQ[$];
	logic [11:0] codes[6];
	logic [11:0] d, d2;
	integer seed = 32'hEE06;
	int errors = 0, checks = 0, k, w;
	always #25 core_clk = ~core_clk;
	acr_readout acr_readout_i (.core_clk(core_clk), .srst(srst), .sclk(sclk),
		.frameSyncN(frameSyncN), .conversionStartPin(conversionStartPin), .convDone(convDone),
		.convData(convData), .convChannel(convChannel), .chainModeSelect(chainModeSelect),
		.markerEnable(markerEnable), .autoTrigger(autoTrigger), .cclkFromSclk(cclkFromSclk),
		.softwareResetBitN(softwareResetBitN), .chainDataIn(chainDataIn), .eocOut(eocOut),
		.eocOe(eocOe), .sdoOut(sdoOut), .sdoOe(sdoOe), .endOfSampling(endOfSampling),
		.conversionClockTick(conversionClockTick), .odrWord(odrWord));
	acr_upstream_model acr_upstream_model_i (.sclk(sclk), .frameSyncN(frameSyncN),
		.upWord(upWord), .chainDataIn(chainDataIn));
	task automatic check(input string name, input logic [23:0] e, input logic [23:0] g);
		checks++;
		if (e !== g) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// Frame sync held low for the whole transfer
	task automatic frame(input int n, input logic [47:0] exp);
		for (int i = 0; i < n; i++)
			expQ.push_back(exp[47-i]);
		@(negedge core_clk) frameSyncN = 0;
		#1 check("sdoOe", 1'b1, sdoOe);
		repeat (n) begin
			#16 sclk = 1; // SCLK runs only inside frames
			#16 sclk = 0;
		end
		@(negedge core_clk) frameSyncN = 1;
		#1 check("sdoOe", 1'b0, sdoOe);
		repeat (8) @(negedge core_clk);
		check("bits left", 1'b0, expQ.size() != 0);
		expQ.delete();
	endtask : frame
	task automatic conv(input logic [11:0] v, input logic ch);
		@(negedge core_clk) begin
			convDone = 1;
			convData = v;
			convChannel = ch;
		end
		@(negedge core_clk) convDone = 0;
		check("eocOut", 1'b1, eocOut);
		convData = ~v;
		repeat (8) @(negedge core_clk); // Frames kept clear of conversion end
	endtask : conv
	function automatic logic [47:0] word(input logic [11:0] v, input logic m);
		return {v, 4'h0, m, 31'h0000_0000};
	endfunction : word
	// Samples on rising sclk, the bit launched by the previous falling edge
	always @(posedge sclk) begin
		if (frameSyncN === 1'b0) begin
			if (expQ.size() == 0)
				check("extra bit", 1'b0, 1'b1);
			else
				check("sdoOut", expQ.pop_front(), sdoOut);
		end
	end
	initial begin
		codes = '{12'hFFF, 12'h800, 12'h7FF, 12'h000, 12'h000, 12'h000};
		codes[4] = 12'($random(seed));
		codes[5] = 12'($random(seed));
		repeat (3) @(negedge core_clk);
		srst = 0;
		repeat (8) @(negedge core_clk);
		frame(16, 48'hFFFF_0000_0000);
		for (k = 0; k < 6; k++) begin
			markerEnable = k[0];
			conv(codes[k], k[1]);
			check("odrWord", k[0] ? {codes[k], 4'h0, k[1], 7'h00} : {8'h00, codes[k], 4'h0},
				odrWord);
			w = k[0] ? 24 : 16;
			frame(w, word(codes[k], k[0] & k[1]));
		end
		frame(4, word(codes[5], 1'b0));
		markerEnable = 0;
		d = 12'($random(seed));
		d2 = 12'($random(seed));
		conv(d, 1'b0);
		fork
			frame(16, word(d, 1'b0));
			begin
				repeat (3) @(negedge core_clk);
				conv(d2, 1'b0);
			end
		join
		frame(16, word(d2, 1'b0));
		chainModeSelect = 1;
		#1 check("eocOe", 1'b0, eocOe);
		upWord = 16'($random(seed));
		conv(d, 1'b0);
		conv(d2, 1'b1);
		frame(32, {d2, 4'h0, upWord, 16'h0000});
		@(negedge core_clk) conversionStartPin = 1; // Frame sync high, SCLK quiet
		repeat (4) @(negedge core_clk);
		conversionStartPin = 0;
		for (k = 0; k < 10 && endOfSampling !== 1'b1; k++)
			@(negedge core_clk);
		check("endOfSampling", 1'b1, endOfSampling);
		@(negedge core_clk) autoTrigger = 1;
		@(negedge core_clk) convDone = 1;
		@(negedge core_clk) convDone = 0;
		for (k = 0; k < 10 && endOfSampling !== 1'b1; k++)
			@(negedge core_clk);
		check("autoEos", 1'b1, endOfSampling);
		@(negedge core_clk) autoTrigger = 0;
		for (k = 0; k < 2; k++) begin
			cclkFromSclk = k[0];
			w = 0;
			repeat (8) @(negedge core_clk) w += int'(conversionClockTick);
			check("cclkTicks", k[0] ? 24'h000000 : 24'h000004, 24'(w));
		end
		cclkFromSclk = 0;
		softwareResetBitN = 0;
		chainModeSelect = 0;
		repeat (3) @(negedge core_clk);
		softwareResetBitN = 1;
		#1 check("eocOe", 1'b1, eocOe);
		repeat (8) @(negedge core_clk);
		frame(16, 48'hFFFF_0000_0000);
		frame(16, word(12'hFFF, 1'b0));
		stop_test();
	end
endmodule : testbench
`default_nettype wire
